// File: include/ssr_pkg.sv
package ssr_pkg;

  // ----------------------------------------------------------------
  // Bus addresses and framing
  // ----------------------------------------------------------------
  localparam logic [1:0] SSR_ADDR_MSB = 2'h2;       // Fixed upper bits "10"
  localparam logic [6:0] SSR_BCAST_ADDR = 7'h5f;    // Mass-write 1011 111
  localparam logic [6:0] SSR_ARA_ADDR = 7'h0c;      // Alert response 0001 100
  localparam logic [3:0] SSR_BYTE_BITS = 4'h8;
  localparam logic [1:0] SSR_STRAP_WAIT = 2'h3;     // Cycles before strap catch
  localparam int SSR_REG_COUNT = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Level on a three-state strap pin, as resolved by the pad
  typedef enum logic [1:0] {
    SSR_STRAP_LOW,
    SSR_STRAP_HIGH,
    SSR_STRAP_OPEN
  } ssr_strap_t;

  typedef enum logic [2:0] {
    SSR_IDLE,
    SSR_RECV,
    SSR_ACK,
    SSR_SEND,
    SSR_MACK
  } ssr_state_t;

  typedef enum logic [1:0] {
    SSR_K_ADDR,
    SSR_K_CMD,
    SSR_K_DATA
  } ssr_kind_t;

  // Register write strobe with its target and data
  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [7:0] data;
  } ssr_reg_wr_t;

  // Strap pair to the low five address bits (hi pin, lo pin)
  function automatic logic [4:0] ssr_strap_low5(input ssr_strap_t hi,
                                                input ssr_strap_t lo);
    logic [4:0] r;
    r = 5'h0a;
    unique case ({hi, lo})
      {SSR_STRAP_OPEN, SSR_STRAP_LOW}: r = 5'h08;
      {SSR_STRAP_HIGH, SSR_STRAP_OPEN}: r = 5'h09;
      {SSR_STRAP_OPEN, SSR_STRAP_OPEN}: r = 5'h0a;
      {SSR_STRAP_OPEN, SSR_STRAP_HIGH}: r = 5'h0b;
      {SSR_STRAP_LOW, SSR_STRAP_LOW}: r = 5'h0c;
      {SSR_STRAP_HIGH, SSR_STRAP_HIGH}: r = 5'h0d;
      {SSR_STRAP_LOW, SSR_STRAP_OPEN}: r = 5'h0e;
      {SSR_STRAP_LOW, SSR_STRAP_HIGH}: r = 5'h0f;
      {SSR_STRAP_HIGH, SSR_STRAP_LOW}: r = 5'h19;
      default: r = 5'h0a;
    endcase
    return r;
  endfunction

endpackage

// File: rtl/ssr_port.sv
`timescale 1ns/1ps
// Function
// - Read-write slave handling byte write and byte read, one register per transfer.
// - Slave address comes from two three-state strap pins, nine choices.
// - Upper two address bits are fixed at one-zero.
// - Mass-write address is accepted for writes whatever the strap.
// - Mass-write address ignored unless the enable bit is one.
// - While alerting, ack alert address, return own address, release alert.
// - Transmitter releases SDA in ack slot; receiver holds it low throughout.
// - Write is start, address with write bit, ack, command byte.
// - Command byte loads only its low three bits into the pointer.
// - First data byte is acked and stored into the pointed register.
// - Further write data bytes are acked and discarded.
// - Read uses repeated start, same address with read bit, then data.
// - Master ack after read byte repeats the same register contents.
// - Direct addressing by the master also releases the alert output.
// - Alert is not asserted again until a new fault flag rises.
module ssr_port (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire ssr_pkg::ssr_strap_t addr_strap_lo,
  input wire ssr_pkg::ssr_strap_t addr_strap_hi,
  input wire logic broadcast_write_enable,
  input wire logic [7:0] fault_flags,
  output logic alert_out_pin_o,
  output logic alert_out_pin_oe,
  output logic [2:0] reg_index,
  input wire logic [7:0] reg_rd_data,
  output ssr_pkg::ssr_reg_wr_t reg_wr
);
  import ssr_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers and line events
  // ----------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_d_q;
  logic sda_s1_q, sda_s2_q, sda_d_q;
  ssr_strap_t lo_s1_q, lo_s2_q, hi_s1_q, hi_s2_q;

  // Bus pins and straps come from outside, two flops each
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_s1_q, scl_s2_q, scl_d_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_d_q} <= 3'h7;
      lo_s1_q <= SSR_STRAP_OPEN;
      lo_s2_q <= SSR_STRAP_OPEN;
      hi_s1_q <= SSR_STRAP_OPEN;
      hi_s2_q <= SSR_STRAP_OPEN;
    end else if (clk_en) begin
      {scl_s1_q, scl_s2_q, scl_d_q} <= {scl_i, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_d_q} <= {sda_i, sda_s1_q, sda_s2_q};
      lo_s1_q <= addr_strap_lo;
      lo_s2_q <= lo_s1_q;
      hi_s1_q <= addr_strap_hi;
      hi_s2_q <= hi_s1_q;
    end
  end

  // Only the second flop and its delayed copy feed edge detection
  wire scl_rise = scl_s2_q & ~scl_d_q;
  wire scl_fall = ~scl_s2_q & scl_d_q;
  wire bus_start = scl_s2_q & scl_d_q & ~sda_s2_q & sda_d_q;
  wire bus_stop = scl_s2_q & scl_d_q & sda_s2_q & ~sda_d_q;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [1:0] strap_wait_q;
  logic [6:0] own_addr_q;

  // Caught once after reset, so a strap change mid-traffic cannot move
  // the address under a transfer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait_q <= '0;
      own_addr_q <= {SSR_ADDR_MSB, 5'h0a};
    end else if (clk_en && strap_wait_q != SSR_STRAP_WAIT) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      own_addr_q <= {SSR_ADDR_MSB, ssr_strap_low5(hi_s2_q, lo_s2_q)};
    end
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  ssr_state_t st_q, st_d;
  ssr_kind_t kind_q, kind_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic sda_oe_q, sda_oe_d, rd_q, rd_d, ara_q, ara_d, first_q, first_d;
  logic [2:0] ptr_q, ptr_d;
  ssr_reg_wr_t wr_q, wr_d;
  logic alert_q, alert_d, rel;
  logic [7:0] fault_prev_q;

  // Address decode on the received byte
  wire own_hit = sh_q[7:1] == own_addr_q;
  wire bcast_hit = sh_q[7:1] == SSR_BCAST_ADDR && !sh_q[0]
                   && broadcast_write_enable;
  wire ara_hit = sh_q[7:1] == SSR_ARA_ADDR && sh_q[0] && alert_q;
  wire addr_hit = own_hit | bcast_hit | ara_hit;
  wire byte_done = scl_fall && cnt_q == SSR_BYTE_BITS;
  wire [7:0] load_byte = ara_q ? {own_addr_q, 1'b0} : reg_rd_data;
  wire new_fault = |(fault_flags & ~fault_prev_q);

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sda_oe_d = sda_oe_q;
    rd_d = rd_q;
    ara_d = ara_q;
    first_d = first_q;
    ptr_d = ptr_q;
    wr_d = wr_q;
    wr_d.valid = 1'b0;
    rel = 1'b0;
    if (bus_stop) begin
      st_d = SSR_IDLE;
      sda_oe_d = 1'b0;
    end else if (bus_start) begin
      st_d = SSR_RECV;
      kind_d = SSR_K_ADDR;
      cnt_d = '0;
      sda_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        SSR_IDLE: begin
        end
        SSR_RECV: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_d = '0;
            st_d = SSR_ACK;
            sda_oe_d = 1'b1;
            if (kind_q == SSR_K_ADDR) begin
              if (addr_hit) begin
                rd_d = sh_q[0];
                ara_d = ara_hit;
                first_d = 1'b1;
                rel = own_hit;
              end else begin
                st_d = SSR_IDLE;
                sda_oe_d = 1'b0;
              end
            end else if (kind_q == SSR_K_CMD) begin
              ptr_d = sh_q[2:0];
            end else if (first_q) begin
              wr_d = '{valid: 1'b1, index: ptr_q, data: sh_q};
              first_d = 1'b0;
            end
          end
        end
        SSR_ACK: begin
          if (scl_fall) begin
            if (kind_q == SSR_K_ADDR && rd_q) begin
              st_d = SSR_SEND;
              sh_d = load_byte;
              sda_oe_d = ~load_byte[7];
              cnt_d = 4'h1;
            end else begin
              st_d = SSR_RECV;
              sda_oe_d = 1'b0;
              kind_d = kind_q == SSR_K_ADDR ? SSR_K_CMD : SSR_K_DATA;
            end
          end
        end
        SSR_SEND: begin
          if (byte_done) begin
            st_d = SSR_MACK;
            sda_oe_d = 1'b0;
            rel = ara_q;
          end else if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b1};
            sda_oe_d = ~sh_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
        SSR_MACK: begin
          if (scl_rise && sda_s2_q) begin
            st_d = SSR_IDLE;
          end else if (scl_fall) begin
            st_d = SSR_SEND;
            sh_d = load_byte;
            sda_oe_d = ~load_byte[7];
            cnt_d = 4'h1;
          end
        end
      endcase
    end
  end

  // Alert is edge driven: a standing fault cannot re-arm it, and a new
  // fault in the cycle of a release wins
  assign alert_d = new_fault ? 1'b1 : (rel ? 1'b0 : alert_q);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= SSR_IDLE;
      kind_q <= SSR_K_ADDR;
      {cnt_q, sh_q, ptr_q} <= '0;
      {sda_oe_q, rd_q, ara_q, first_q, alert_q} <= '0;
      wr_q <= '0;
      fault_prev_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      kind_q <= kind_d;
      {cnt_q, sh_q, ptr_q} <= {cnt_d, sh_d, ptr_d};
      {sda_oe_q, rd_q, ara_q, first_q} <= {sda_oe_d, rd_d, ara_d, first_d};
      wr_q <= wr_d;
      alert_q <= alert_d;
      fault_prev_q <= fault_flags;
    end
  end

  // Open-drain drivers only ever pull low
  assign sda_o = 1'b0 & sda_oe_q;
  assign sda_oe = sda_oe_q;
  assign alert_out_pin_o = 1'b0 & alert_q;
  assign alert_out_pin_oe = alert_q;
  assign reg_index = ptr_q;
  assign reg_wr = wr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_byte_done;
    clk_en && st_q == SSR_RECV && kind_q == SSR_K_ADDR && byte_done;
  endsequence

  chk_fixed_msb: assert property (own_addr_q[6:5] == 2'h2)
    else $error("address upper bits not one-zero");
  chk_foreign_addr: assert property ((s_addr_byte_done and !addr_hit)
    |=> st_q == SSR_IDLE && !sda_oe)
    else $error("drove bus for foreign address");
  chk_bcast_gate: assert property ((s_addr_byte_done and
    (sh_q[7:1] == SSR_BCAST_ADDR && !broadcast_write_enable
    && own_addr_q != SSR_BCAST_ADDR)) |=> !sda_oe)
    else $error("mass write acked while disabled");
  chk_ack_hold: assert property (st_q == SSR_ACK |-> sda_oe)
    else $error("ack slot not held low");
  chk_ptr_load: assert property (clk_en && st_q == SSR_RECV
    && kind_q == SSR_K_CMD && byte_done |=> reg_index == $past(sh_q[2:0]))
    else $error("pointer not loaded from command");
  chk_one_write: assert property (reg_wr.valid |=> !reg_wr.valid
    && !first_q)
    else $error("more than one write per transfer");
  chk_write_ptr: assert property (reg_wr.valid
    |-> reg_wr.index == reg_index && st_q == SSR_ACK)
    else $error("write strobe target mismatch");
  chk_ara_release: assert property (clk_en && st_q == SSR_SEND && ara_q
    && byte_done && !new_fault |=> !alert_out_pin_oe)
    else $error("alert kept after address returned");
  chk_alert_cause: assert property ($rose(alert_out_pin_oe)
    |-> $past(new_fault))
    else $error("alert raised without a new fault");
  chk_mack_repeat: assert property (clk_en && st_q == SSR_MACK
    && scl_fall && !bus_start && !bus_stop |=> st_q == SSR_SEND
    && sh_q == $past(load_byte))
    else $error("second read byte differs");

endmodule

// File: bench/ssr_master.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus master model, SDA resolved by the bench as a wired AND
// ------------------------------------------------------------
module ssr_master (
  input wire logic ref_clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda
);
  // Bus idles with both lines high; SCL stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Low and high phases of 4 cycles each, a 400 ns bit; SDA moves one
  // cycle after SCL falls, and the slave's change three cycles after it
  // still lands before SCL rises, so neither looks like a stop
  task automatic bit_x(input logic b, output logic r);
    sda <= b;
    clk(3);
    scl <= 1'b1;
    clk(2);
    r = sda_bus;
    clk(2);
    scl <= 1'b0;
    clk(1);
  endtask
  // Also serves as repeated start
  task automatic start();
    sda <= 1'b1;
    clk(5);
    scl <= 1'b1;
    clk(4);
    sda <= 1'b0;
    clk(4);
    scl <= 1'b0;
    clk(2);
  endtask
  task automatic stop();
    sda <= 1'b0;
    clk(5);
    scl <= 1'b1;
    clk(4);
    sda <= 1'b1;
    clk(4);
  endtask
  // Released in the ack slot so the slave alone decides the level
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~mack, r);
  endtask
endmodule

// File: bench/ssr_port_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Slave port bench
// ------------------------------------------------------------
module ssr_port_tb;
  import ssr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic bcast_en = 1'b0;
  logic clk_en = 1'b1;
  logic scl, m_sda, sda_o, sda_oe, al_o, al_oe, ack;
  ssr_strap_t st_lo = SSR_STRAP_OPEN;
  ssr_strap_t st_hi = SSR_STRAP_OPEN;
  logic [7:0] flags = 8'h00;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] d1, d2;
  logic [7:0] regs [8];
  logic [6:0] own;
  logic [2:0] reg_index;
  ssr_reg_wr_t reg_wr, last_wr;
  int failures = 0;
  int checked = 0;
  int wr_count = 0;
  wire sda_bus = m_sda & (sda_oe ? sda_o : 1'b1);

  always #25 ref_clk = ~ref_clk;

  ssr_port DUT (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_lo(st_lo), .addr_strap_hi(st_hi),
    .broadcast_write_enable(bcast_en), .fault_flags(flags),
    .alert_out_pin_o(al_o), .alert_out_pin_oe(al_oe),
    .reg_index(reg_index), .reg_rd_data(rd_data), .reg_wr(reg_wr));
  ssr_master m (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl),
    .sda(m_sda));

  // Register file behind the port; read data lags the pointer a cycle
  always @(posedge ref_clk) begin
    rd_data <= regs[reg_index];
    if (reg_wr.valid === 1'b1) begin
      regs[reg_wr.index] <= reg_wr.data;
      last_wr <= reg_wr;
      wr_count <= wr_count + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Straps are only caught just after reset, so each setting resets
  task automatic do_reset(input ssr_strap_t h, input ssr_strap_t l);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    st_hi <= h;
    st_lo <= l;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic addr(input logic [6:0] a, input logic rw);
    m.start();
    m.wr_byte({a, rw}, ack);
  endtask

  task automatic t_straps();
    ssr_strap_t hs [9] = '{SSR_STRAP_OPEN, SSR_STRAP_HIGH, SSR_STRAP_OPEN,
      SSR_STRAP_OPEN, SSR_STRAP_LOW, SSR_STRAP_HIGH, SSR_STRAP_LOW,
      SSR_STRAP_LOW, SSR_STRAP_HIGH};
    ssr_strap_t ls [9] = '{SSR_STRAP_LOW, SSR_STRAP_OPEN, SSR_STRAP_OPEN,
      SSR_STRAP_HIGH, SSR_STRAP_LOW, SSR_STRAP_HIGH, SSR_STRAP_OPEN,
      SSR_STRAP_HIGH, SSR_STRAP_LOW};
    logic [4:0] lows [9] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
      5'h0e, 5'h0f, 5'h19};
    for (int i = 0; i < 9; i++) begin
      do_reset(hs[i], ls[i]);
      own = {2'h2, lows[i]};
      addr(own, 1'b0);
      check(16'(ack), 16'h1);
      m.stop();
      addr(own ^ 7'h20, 1'b0);
      check(16'(ack), 16'h0);
      m.stop();
    end
    $display("straps test done");
  endtask

  task automatic t_write_read();
    int n;
    n = wr_count;
    addr(own, 1'b0);
    m.wr_byte(8'hfd, ack);
    check(16'(reg_index), 16'h5);
    m.wr_byte(8'h3c, ack);
    check(16'(ack), 16'h1);
    check(16'(last_wr), 16'h0d3c);
    m.wr_byte(8'ha5, ack);
    check(16'(ack), 16'h1);
    m.stop();
    check(16'(wr_count - n), 16'h1);
    addr(own, 1'b0);
    m.wr_byte(8'h05, ack);
    addr(own, 1'b1);
    check(16'(ack), 16'h1);
    m.rd_byte(1'b1, d1);
    m.rd_byte(1'b0, d2);
    m.stop();
    check({d1, d2}, 16'h3c3c);
    $display("write read test done");
  endtask

  task automatic t_bcast();
    bcast_en <= 1'b0;
    addr(7'h5f, 1'b0);
    check(16'(ack), 16'h0);
    m.stop();
    bcast_en <= 1'b1;
    addr(7'h5f, 1'b0);
    check(16'(ack), 16'h1);
    m.wr_byte(8'h02, ack);
    m.wr_byte(8'h77, ack);
    m.stop();
    check(16'(last_wr), 16'h0a77);
    addr(7'h5f, 1'b1);
    check(16'(ack), 16'h0);
    m.stop();
    $display("broadcast test done");
  endtask

  task automatic t_alert();
    addr(7'h0c, 1'b1);
    check(16'({ack, al_oe}), 16'h0);
    m.stop();
    flags <= 8'h01;
    repeat (3) @(posedge ref_clk);
    check(16'({al_oe, al_o}), 16'h2);
    addr(7'h0c, 1'b1);
    check(16'(ack), 16'h1);
    m.rd_byte(1'b0, d1);
    m.stop();
    check({d1, 7'h0, al_oe}, {own, 1'b0, 8'h00});
    flags <= 8'h03;
    repeat (3) @(posedge ref_clk);
    check(16'(al_oe), 16'h1);
    addr(own, 1'b0);
    m.stop();
    check(16'(al_oe), 16'h0);
    // A frozen block must not see a new fault until the enable returns
    clk_en <= 1'b0;
    flags <= 8'h07;
    repeat (3) @(posedge ref_clk);
    check(16'(al_oe), 16'h0);
    clk_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(16'(al_oe), 16'h1);
    $display("alert test done");
  endtask

  // Any hang ends in the same closing report
  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      regs[i] = 8'h10 + 8'(i);
    end
    t_straps();
    t_write_read();
    t_bcast();
    t_alert();
    summarize();
  end
endmodule
